// ---- logic/drive_flags_pkg.sv ----
// What this block does
// - Full-scale select 0 scales analogue reference by first setting, 1 by second; resets 0.
// - Reserved-ref select 1 takes the mode's reserved reference, 0 the selected source.
// - Reference freeze 1 holds the last reference; 0 lets it track the input.
// - Left or right limit forces negative or positive reference to zero on stop ramp.
// - Stop request 1 halts the motor using the limit/stop deceleration ramp.
// - At-speed is 1 when speed difference, or speed in window mode, is between thresholds.
// - Soft enable resets to 1; while 0 the power stage cannot start.
// - Low-voltage mode connects inrush circuit when disabled and delays start by 120 ms.
// - Digital-ref 0 picks analogue; else source 0 picks internal, 1 picks frequency input.
// - Frequency input format defaults to 1 for quadrature, 0 for frequency plus direction.
// - Overspeed flag is 1 when absolute speed exceeds the overspeed threshold.
// - Zero-speed flag when speed is zero; forward flag when speed is positive.
// - Healthy flag is 1 only when no alarm is active.
// - Time slot flag 1 means the external mode runs every 2 ms, else 512 us.
// - Three-bit resolution field selects 16384 down to 128 counts; default 1024.
// - Offset reset trims the analogue offset away only when it is under 200 mV.
// - Current calibration request accepted only while disabled, run at next start.
// - Alarm reset clears both alarm codes, refused for checksum alarms 10 and 11, and dropped when a global default is accepted in the same write.
// - Mode default command executes only while reserved-ref select is 0.
// - Global default needs PLC run 0, and clears alarm codes on a checksum alarm.
// - Save refused on checksum error; a failed save raises retry for reissue.
package drive_flags_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_CFG  = 8'h08;
   localparam logic [7:0] OFF_CMD  = 8'h0C;
   localparam logic [7:0] OFF_OFS  = 8'h10;
   localparam logic [7:0] OFF_RES  = 8'h14;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int FULL_SCALE_SELECT   = 0;
   localparam int RESERVED_REF_SELECT = 2;
   localparam int REF_FREEZE          = 3;
   localparam int LEFT_LIMIT          = 4;
   localparam int RIGHT_LIMIT         = 5;
   localparam int STOP_REQUEST        = 6;
   localparam int WINDOW_MODE         = 7;
   localparam int SOFT_ENABLE         = 9;
   localparam int LOW_VOLTAGE_ENABLE  = 10;
   localparam int DIGITAL_REF_SELECT  = 12;
   localparam int REF_SOURCE_SELECT   = 13;
   localparam int OVERSPEED_FLAG      = 0;
   localparam int AT_SPEED_FLAG       = 1;
   localparam int ZERO_SPEED_FLAG     = 2;
   localparam int FORWARD_FLAG        = 3;
   localparam int HEALTHY_FLAG        = 4;
   localparam int HW_ENABLE_FLAG      = 5;
   localparam int DRIVE_ENABLED_FLAG  = 12;
   localparam int EXT_MODE_SLOT_FLAG  = 15;
   localparam int EMUL_RES_LSB        = 0;
   localparam int SERIAL_REINIT_CMD   = 3;
   localparam int FREQ_INPUT_FORMAT   = 5;
   localparam int REF_OFFSET_RESET    = 1;
   localparam int EXTENDED_MENU       = 6;
   localparam int SECURITY_LOCK       = 7;
   localparam int CURRENT_CAL_REQUEST = 9;
   localparam int ALARM_RESET_CMD     = 10;
   localparam int MODE_DEFAULT_CMD    = 11;
   localparam int GLOBAL_DEFAULT_CMD  = 12;
   localparam int PLC_RUN             = 13;
   localparam int SAVE_PARAMS_CMD     = 15;
   localparam int RES_RETRY           = 0;
   localparam int RES_CAL_PENDING     = 1;
   localparam int RES_REJECTED        = 2;

   // ----------------------------------------
   // Reset values and masks
   // ----------------------------------------
   localparam logic [15:0] CTRL_RST   = 16'h0200;
   localparam logic [15:0] CTRL_MASK  = 16'h7FFF;
   localparam logic [15:0] CFG_RST    = 16'h0064;
   localparam logic [15:0] CFG_PULSE  = 16'h0008;
   localparam logic [15:0] CMD_RST    = 16'h2000;
   localparam logic [15:0] CMD_PULSE  = 16'h9E00;
   localparam logic [7:0]  ALARM_PLC_CSUM = 8'h0A;
   localparam logic [7:0]  ALARM_PAR_CSUM = 8'h0B;
   localparam logic [16:0] OFFSET_LIMIT_MV = 17'h000C8;
   localparam logic [14:0] EMUL_MAX_COUNTS = 15'h4000;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ        = 100_000_000;
   localparam int INRUSH_MS     = 120;
   localparam int INRUSH_CYCLES = INRUSH_MS * (CLK_HZ / 1000);

   typedef enum logic [1:0] {PWR_OFF, PWR_INRUSH, PWR_RUN} pwr_t;

   // Values arriving from the rest of the drive.
   typedef struct packed {
      logic signed [15:0] measured_speed;
      logic signed [15:0] analog_ref;
      logic signed [15:0] internal_ref;
      logic signed [15:0] freq_ref;
      logic signed [15:0] reserved_ref;
      logic signed [15:0] full_scale_first;
      logic signed [15:0] full_scale_second;
      logic signed [15:0] overspeed_threshold;
      logic signed [15:0] high_speed_threshold;
      logic signed [15:0] low_speed_threshold;
      logic signed [15:0] analog_offset_mv;
      logic signed [15:0] offset_trim;
      logic        [7:0]  active_alarm_code;
      logic               hw_enable;
      logic               ext_mode_slow;
      logic               save_fail;
   } drive_in_t;

   // Values and command strobes sent to the rest of the drive.
   typedef struct packed {
      logic signed [15:0] speed_ref;
      logic               stop_ramp;
      logic               power_enable;
      logic               inrush_connect;
      logic               freq_quadrature;
      logic        [14:0] emul_counts;
      logic               offset_trim_load;
      logic signed [15:0] offset_trim_value;
      logic               alarm_clear;
      logic               mode_default;
      logic               global_default;
      logic               save_params;
      logic               serial_reinit;
      logic               current_cal_run;
   } drive_out_t;

endpackage : drive_flags_pkg

// ---- logic/servo_drive_flag_words.sv ----
`timescale 1ns/1ps
module servo_drive_flag_words
#(
   parameter int INRUSH_CYCLES = drive_flags_pkg::INRUSH_CYCLES
)
(
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [7:0]                 paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire drive_flags_pkg::drive_in_t drv_in,
   output drive_flags_pkg::drive_out_t     drv_out
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [15:0]                ctrl;
      logic [15:0]                cfg;
      logic [15:0]                cmd;
      logic [15:0]                status;
      logic [15:0]                pend_cmd;
      logic                       pend_serial;
      logic                       pend_offset;
      logic                       retry;
      logic                       cal_pending;
      logic                       rejected;
      logic signed [15:0]         ref_hold;
      drive_flags_pkg::pwr_t      pwr;
      logic [23:0]                cnt;
      logic [31:0]                prdata;
      drive_flags_pkg::drive_out_t out;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   // Absolute value widened by one bit so that the most negative input fits.
   function automatic logic [16:0] abs17(input logic signed [15:0] v);
      logic signed [16:0] w;
      w = 17'(v);
      return (w < 0) ? 17'(-w) : 17'(w);
   endfunction : abs17

   // Whether an alarm code is one of the two checksum alarms.
   function automatic logic is_csum(input logic [7:0] code);
      return (code == drive_flags_pkg::ALARM_PLC_CSUM) || (code == drive_flags_pkg::ALARM_PAR_CSUM);
   endfunction : is_csum

   localparam logic [23:0] INRUSH_LAST = 24'(INRUSH_CYCLES - 1);

   // ----------------------------------------
   // Bus handshake
   // ----------------------------------------
   // Zero wait states: read data is captured in the setup cycle.
   logic wr_en;
   logic mapped;
   logic locked;
   assign pready  = 1'b1;
   assign prdata  = state_r.prdata;
   assign drv_out = state_r.out;
   assign wr_en   = psel && penable && pwrite;
   assign locked  = state_r.cmd[drive_flags_pkg::SECURITY_LOCK];
   assign mapped  = (paddr == drive_flags_pkg::OFF_CTRL) || (paddr == drive_flags_pkg::OFF_STAT) ||
                    (paddr == drive_flags_pkg::OFF_CFG)  || (paddr == drive_flags_pkg::OFF_CMD)  ||
                    (paddr == drive_flags_pkg::OFF_OFS)  || (paddr == drive_flags_pkg::OFF_RES);
   assign pslverr = psel && penable && !mapped;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   // Reference path, status flags, command evaluation, power sequencing and bus access.
   always_comb
   begin
      logic signed [15:0] main_ref;
      logic signed [15:0] live_ref;
      logic signed [15:0] ref_now;
      logic signed [31:0] scaled;
      logic signed [15:0] fs;
      logic signed [16:0] diff;
      logic signed [16:0] win_q;
      logic               csum;
      logic               start_ok;
      logic               any_cmd;
      logic               rej;
      main_ref  = 16'sh0000;
      live_ref  = 16'sh0000;
      ref_now   = 16'sh0000;
      scaled    = 32'sh00000000;
      fs        = 16'sh0000;
      diff      = 17'sh00000;
      win_q     = 17'sh00000;
      csum      = is_csum(drv_in.active_alarm_code);
      start_ok  = 1'b0;
      any_cmd   = 1'b0;
      rej       = 1'b0;
      state_nxt = state_r;

      // Strobes last exactly one cycle.
      state_nxt.out.offset_trim_load = 1'b0;
      state_nxt.out.alarm_clear      = 1'b0;
      state_nxt.out.mode_default     = 1'b0;
      state_nxt.out.global_default   = 1'b0;
      state_nxt.out.save_params      = 1'b0;
      state_nxt.out.serial_reinit    = 1'b0;
      state_nxt.out.current_cal_run  = 1'b0;

      // Analogue reference is a Q15 fraction of the selected full scale.
      fs = state_r.ctrl[drive_flags_pkg::FULL_SCALE_SELECT] ? drv_in.full_scale_second
                                                             : drv_in.full_scale_first;
      scaled = drv_in.analog_ref * fs;
      if (state_r.ctrl[drive_flags_pkg::DIGITAL_REF_SELECT])
      begin
         main_ref = state_r.ctrl[drive_flags_pkg::REF_SOURCE_SELECT] ? drv_in.freq_ref
                                                                     : drv_in.internal_ref;
      end
      else
      begin
         main_ref = scaled[30:15];
      end
      live_ref = state_r.ctrl[drive_flags_pkg::RESERVED_REF_SELECT] ? drv_in.reserved_ref
                                                                     : main_ref;

      // A frozen reference keeps the value captured while it still tracked.
      ref_now = state_r.ctrl[drive_flags_pkg::REF_FREEZE] ? state_r.ref_hold : live_ref;
      state_nxt.ref_hold = ref_now;

      // The ramp generator downstream applies the limit/stop rate while stop_ramp is high.
      if (state_r.ctrl[drive_flags_pkg::STOP_REQUEST] ||
          (state_r.ctrl[drive_flags_pkg::LEFT_LIMIT] && (ref_now < 0)) ||
          (state_r.ctrl[drive_flags_pkg::RIGHT_LIMIT] && (ref_now > 0)))
      begin
         state_nxt.out.speed_ref = 16'sh0000;
         state_nxt.out.stop_ramp = 1'b1;
      end
      else
      begin
         state_nxt.out.speed_ref = ref_now;
         state_nxt.out.stop_ramp = 1'b0;
      end

      // Status flags, sampled every cycle.
      diff  = 17'(drv_in.measured_speed) - 17'(ref_now);
      win_q = state_r.ctrl[drive_flags_pkg::WINDOW_MODE] ? 17'(drv_in.measured_speed) : diff;
      state_nxt.status = 16'h0000;
      state_nxt.status[drive_flags_pkg::OVERSPEED_FLAG] =
         abs17(drv_in.measured_speed) > abs17(drv_in.overspeed_threshold);
      state_nxt.status[drive_flags_pkg::AT_SPEED_FLAG] =
         (win_q < 17'(drv_in.high_speed_threshold)) && (win_q > 17'(drv_in.low_speed_threshold));
      state_nxt.status[drive_flags_pkg::ZERO_SPEED_FLAG] = drv_in.measured_speed == 0;
      state_nxt.status[drive_flags_pkg::FORWARD_FLAG]    = drv_in.measured_speed > 0;
      state_nxt.status[drive_flags_pkg::HEALTHY_FLAG]    = drv_in.active_alarm_code == 8'h00;
      state_nxt.status[drive_flags_pkg::HW_ENABLE_FLAG]  = drv_in.hw_enable;
      state_nxt.status[drive_flags_pkg::DRIVE_ENABLED_FLAG] = state_r.pwr == drive_flags_pkg::PWR_RUN;
      state_nxt.status[drive_flags_pkg::EXT_MODE_SLOT_FLAG] = drv_in.ext_mode_slow;

      // Configuration outputs.
      state_nxt.out.freq_quadrature = state_r.cfg[drive_flags_pkg::FREQ_INPUT_FORMAT];
      state_nxt.out.emul_counts =
         drive_flags_pkg::EMUL_MAX_COUNTS >> state_r.cfg[drive_flags_pkg::EMUL_RES_LSB +: 3];

      // Pending commands are judged one cycle after the write and then dropped.
      state_nxt.pend_cmd    = 16'h0000;
      state_nxt.pend_serial = 1'b0;
      state_nxt.pend_offset = 1'b0;
      if (state_r.pend_cmd[drive_flags_pkg::CURRENT_CAL_REQUEST])
      begin
         any_cmd = 1'b1;
         if (state_r.pwr == drive_flags_pkg::PWR_OFF)
            state_nxt.cal_pending = 1'b1;
         else
            rej = 1'b1;
      end
      if (state_r.pend_cmd[drive_flags_pkg::ALARM_RESET_CMD])
      begin
         any_cmd = 1'b1;
         if (!csum)
            state_nxt.out.alarm_clear = 1'b1;
         else
            rej = 1'b1;
      end
      if (state_r.pend_cmd[drive_flags_pkg::MODE_DEFAULT_CMD])
      begin
         any_cmd = 1'b1;
         if (!state_r.ctrl[drive_flags_pkg::RESERVED_REF_SELECT])
            state_nxt.out.mode_default = 1'b1;
         else
            rej = 1'b1;
      end
      if (state_r.pend_cmd[drive_flags_pkg::GLOBAL_DEFAULT_CMD])
      begin
         any_cmd = 1'b1;
         if (!state_r.cmd[drive_flags_pkg::PLC_RUN])
         begin
            state_nxt.out.global_default = 1'b1;
            state_nxt.out.alarm_clear    = csum;
         end
         else
            rej = 1'b1;
      end
      if (state_r.pend_cmd[drive_flags_pkg::SAVE_PARAMS_CMD])
      begin
         any_cmd = 1'b1;
         if (!csum)
         begin
            state_nxt.out.save_params = 1'b1;
            state_nxt.retry           = 1'b0;
         end
         else
            rej = 1'b1;
      end
      if (state_r.pend_serial)
      begin
         any_cmd = 1'b1;
         state_nxt.out.serial_reinit = 1'b1;
      end
      if (state_r.pend_offset)
      begin
         any_cmd = 1'b1;
         if (abs17(drv_in.analog_offset_mv) < drive_flags_pkg::OFFSET_LIMIT_MV)
         begin
            state_nxt.out.offset_trim_load  = 1'b1;
            state_nxt.out.offset_trim_value = drv_in.offset_trim - drv_in.analog_offset_mv;
         end
         else
            rej = 1'b1;
      end
      if (any_cmd)
         state_nxt.rejected = rej;
      // A failure report wins over the clear of an accepted save.
      if (drv_in.save_fail)
         state_nxt.retry = 1'b1;

      // Power stage sequencing.
      start_ok = drv_in.hw_enable && state_r.ctrl[drive_flags_pkg::SOFT_ENABLE] &&
                 (drv_in.active_alarm_code == 8'h00);
      case (state_r.pwr)
         drive_flags_pkg::PWR_OFF:
         begin
            state_nxt.cnt = 24'h000000;
            if (start_ok)
               state_nxt.pwr = state_r.ctrl[drive_flags_pkg::LOW_VOLTAGE_ENABLE] ? drive_flags_pkg::PWR_INRUSH
                                                                                 : drive_flags_pkg::PWR_RUN;
         end
         drive_flags_pkg::PWR_INRUSH:
         begin
            if (!start_ok)
               state_nxt.pwr = drive_flags_pkg::PWR_OFF;
            else if (state_r.cnt == INRUSH_LAST)
               state_nxt.pwr = drive_flags_pkg::PWR_RUN;
            else
               state_nxt.cnt = state_r.cnt + 24'h000001;
         end
         drive_flags_pkg::PWR_RUN:
         begin
            if (!start_ok)
               state_nxt.pwr = drive_flags_pkg::PWR_OFF;
         end
         default:
         begin
            state_nxt.pwr = drive_flags_pkg::PWR_OFF;
         end
      endcase
      // The calibration waits for the next entry into run.
      if ((state_nxt.pwr == drive_flags_pkg::PWR_RUN) && (state_r.pwr != drive_flags_pkg::PWR_RUN) &&
          state_r.cal_pending)
      begin
         state_nxt.out.current_cal_run = 1'b1;
         state_nxt.cal_pending         = 1'b0;
      end
      state_nxt.out.power_enable   = state_nxt.pwr == drive_flags_pkg::PWR_RUN;
      state_nxt.out.inrush_connect = state_r.ctrl[drive_flags_pkg::LOW_VOLTAGE_ENABLE] &&
                                     (state_nxt.pwr != drive_flags_pkg::PWR_RUN);

      // Read data is latched in the setup cycle so it is stable in the access cycle.
      if (psel && !penable && !pwrite)
      begin
         case (paddr)
            drive_flags_pkg::OFF_CTRL: state_nxt.prdata = {16'h0000, state_r.ctrl};
            drive_flags_pkg::OFF_STAT: state_nxt.prdata = {16'h0000, state_r.status};
            drive_flags_pkg::OFF_CFG:  state_nxt.prdata = {16'h0000, state_r.cfg};
            drive_flags_pkg::OFF_CMD:  state_nxt.prdata = {16'h0000, state_r.cmd};
            drive_flags_pkg::OFF_RES:  state_nxt.prdata = {29'h00000000, state_r.rejected,
                                                           state_r.cal_pending, state_r.retry};
            default:                   state_nxt.prdata = 32'h00000000;
         endcase
      end

      // Writes; a locked bank still lets software clear the lock itself.
      if (wr_en)
      begin
         case (paddr)
            drive_flags_pkg::OFF_CTRL:
            begin
               if (!locked)
                  state_nxt.ctrl = pwdata[15:0] & drive_flags_pkg::CTRL_MASK;
            end
            drive_flags_pkg::OFF_CFG:
            begin
               if (!locked)
               begin
                  state_nxt.cfg = pwdata[15:0] & ~drive_flags_pkg::CFG_PULSE;
                  state_nxt.pend_serial = pwdata[drive_flags_pkg::SERIAL_REINIT_CMD] &&
                                          state_r.cmd[drive_flags_pkg::EXTENDED_MENU];
               end
            end
            drive_flags_pkg::OFF_CMD:
            begin
               state_nxt.cmd = pwdata[15:0] & ~drive_flags_pkg::CMD_PULSE;
               if (!locked)
                  state_nxt.pend_cmd = pwdata[15:0] & drive_flags_pkg::CMD_PULSE;
            end
            drive_flags_pkg::OFF_OFS:
            begin
               state_nxt.pend_offset = pwdata[drive_flags_pkg::REF_OFFSET_RESET] && !locked &&
                                       state_r.cmd[drive_flags_pkg::EXTENDED_MENU];
            end
            default:
            begin
               state_nxt.pend_offset = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Every field takes a constant under reset.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r      <= '0;
         state_r.ctrl <= drive_flags_pkg::CTRL_RST;
         state_r.cfg  <= drive_flags_pkg::CFG_RST;
         state_r.cmd  <= drive_flags_pkg::CMD_RST;
         state_r.pwr  <= drive_flags_pkg::PWR_OFF;
         state_r.out.freq_quadrature <= 1'b1;
         state_r.out.emul_counts     <= drive_flags_pkg::EMUL_MAX_COUNTS >> 4;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

endmodule : servo_drive_flag_words

// ---- sim/servo_drive_flag_words_assertions.sv ----
`timescale 1ns/1ps
// Port watcher; the alarm clear, offset trim and save strobes and the power outputs are tied back to their causes.
module servo_drive_flag_words_assertions
#(
   parameter int INRUSH_CYCLES = 20
)
(
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [7:0]                 paddr,
   input wire logic [31:0]                pwdata,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire drive_flags_pkg::drive_in_t drv_in,
   input wire drive_flags_pkg::drive_out_t drv_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_clr_once; drv_out.alarm_clear |=> !drv_out.alarm_clear; endproperty
   a_clr_once: assert property (p_clr_once) else $error("alarm clear strobe too long");
   property p_pwr_cause; $rose(drv_out.power_enable) |-> $past(drv_in.hw_enable); endproperty
   a_pwr_cause: assert property (p_pwr_cause) else $error("power stage started without enable");
   property p_inrush_off; drv_out.inrush_connect |-> !drv_out.power_enable; endproperty
   a_inrush_off: assert property (p_inrush_off) else $error("inrush circuit while running");
   // Only the two checksum codes block a reset; codes above them are ordinary alarms.
   property p_alarm_ok; drv_out.alarm_clear && !drv_out.global_default |->
      !($past(drv_in.active_alarm_code) inside {8'h0A, 8'h0B}); endproperty
   a_alarm_ok: assert property (p_alarm_ok) else $error("alarm reset on checksum alarm");
   property p_glob_clr; drv_out.global_default && ($past(drv_in.active_alarm_code) inside {8'h0A, 8'h0B})
      |-> drv_out.alarm_clear; endproperty
   a_glob_clr: assert property (p_glob_clr) else $error("checksum alarm kept on default");
   property p_trim_rng; drv_out.offset_trim_load |->
      ($past(drv_in.analog_offset_mv) > -16'sd200) && ($past(drv_in.analog_offset_mv) < 16'sd200); endproperty
   a_trim_rng: assert property (p_trim_rng) else $error("offset trim outside window");
   property p_save_ok; drv_out.save_params |->
      !($past(drv_in.active_alarm_code) inside {8'h0A, 8'h0B}); endproperty
   a_save_ok: assert property (p_save_ok) else $error("save during checksum error");
   property p_stop_zero; drv_out.stop_ramp |-> drv_out.speed_ref == 16'h0000; endproperty
   a_stop_zero: assert property (p_stop_zero) else $error("reference not forced to zero");
endmodule : servo_drive_flag_words_assertions
bind servo_drive_flag_words servo_drive_flag_words_assertions #(.INRUSH_CYCLES(INRUSH_CYCLES)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .drv_in(drv_in), .drv_out(drv_out));

// ---- sim/servo_drive_flag_words_tb.sv ----
`timescale 1ns/1ps
module servo_drive_flag_words_tb;
   logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]                  paddr;
   logic [31:0]                 pwdata, prdata;
   logic [15:0]                 e, m, eq[$], mq[$];
   logic signed [15:0]          s;
   drive_flags_pkg::drive_in_t  drv_in;
   drive_flags_pkg::drive_out_t drv_out;
   int                          n_errors, num_checks, npul[4], epul[4];
   int                          seed = 32'hE727D9C3;
   servo_drive_flag_words #(.INRUSH_CYCLES(20)) u_servo_drive_flag_words (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .drv_in(drv_in), .drv_out(drv_out));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] v, input logic [31:0] x, input string n);
      num_checks++;
      if (v !== x)
      begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", n, x, v);
      end
   endtask : chk
   // Reads note their expectation; the monitor compares when the answer comes.
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [15:0] k);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 16'h0000, d};
      if (!w) begin eq.push_back(d); mq.push_back(k); end
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (!pready);
      {psel, penable} <= 2'b00;
   endtask : apb
   // Commands settle within two edges, so three are waited before the next step.
   task automatic cmd(input logic [7:0] a, input logic [15:0] d, input logic [7:0] c, input int k);
      drv_in.active_alarm_code <= c;
      apb(1'b1, a, d, 16'h0000);
      repeat (3) @(negedge pclk);
      if (k < 4) epul[k]++;
   endtask : cmd
   task automatic print_verdict;
      if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // Clock and watchdog.
   initial begin pclk = 1'b0; forever #5 pclk = ~pclk; end
   initial begin repeat (5000) @(posedge pclk); n_errors++; print_verdict(); end
   // Monitor: counts strobes and checks every completed read.
   always @(posedge pclk)
   if (presetn)
   begin
      npul[0] += drv_out.alarm_clear;
      npul[1] += drv_out.offset_trim_load;
      npul[2] += drv_out.global_default;
      npul[3] += drv_out.save_params;
      if (psel && penable && pready)
      begin
         chk(pslverr, paddr > 8'h14, "err");
         if (!pwrite)
         begin
            e = eq.pop_front();
            m = mq.pop_front();
            chk(prdata & {16'hFFFF, m}, {16'h0000, e & m}, "rd");
         end
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      drv_in = '0;
      drv_in.overspeed_threshold = 16'h03E8;
      drv_in.high_speed_threshold = 16'h01F4;
      drv_in.low_speed_threshold = 16'hFE0C;
      drv_in.offset_trim = 16'h0100;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk(drv_out.freq_quadrature, 1, "quad");
      chk(drv_out.emul_counts, 15'h0400, "emul");
      apb(0, 8'h00, 16'h0200, 16'hFFFF);
      apb(0, 8'h08, 16'h0064, 16'hFFFF);
      apb(0, 8'h18, 16'h0000, 16'hFFFF);
      apb(1, 8'h00, 16'h0680, 16'h0000);
      repeat (2) @(negedge pclk);
      chk(drv_out.inrush_connect, 1, "inrush");
      drv_in.hw_enable <= 1'b1;
      repeat (5) @(negedge pclk);
      chk(drv_out.power_enable, 0, "pwr");
      repeat (25) @(negedge pclk);
      chk({drv_out.power_enable, drv_out.inrush_connect}, 2'b10, "pwr");
      for (int i = 0; i < 8; i++)
      begin
         s = (i == 0) ? 16'h0000 : 16'($random(seed) % 2048);
         drv_in.measured_speed <= s;
         drv_in.ext_mode_slow <= i[0];
         // The status word is registered, so one edge must pass before the read setup captures it.
         @(posedge pclk);
         apb(0, 8'h04, {i[0], 9'h000, 1'b1, 1'b1, s > 0, s == 0, s > -500 && s < 500, s > 1000 || s < -1000},
             16'h803F);
      end
      cmd(8'h0C, 16'h0440, 8'h0A, 4);
      apb(0, 8'h14, 16'h0004, 16'h0004);
      cmd(8'h0C, 16'h0440, 8'h03, 0);
      cmd(8'h0C, 16'h1040, 8'h0A, 2);
      epul[0]++;
      cmd(8'h0C, 16'h8040, 8'h00, 3);
      drv_in.save_fail <= 1'b1;
      @(posedge pclk);
      apb(0, 8'h14, 16'h0001, 16'h0001);
      drv_in.analog_offset_mv <= 16'h00C8;
      cmd(8'h10, 16'h0002, 8'h00, 4);
      drv_in.analog_offset_mv <= 16'($random(seed) % 200);
      cmd(8'h10, 16'h0002, 8'h00, 1);
      chk($unsigned(drv_out.offset_trim_value), 16'(16'h0100 - drv_in.analog_offset_mv), "trim");
      cmd(8'h0C, 16'h00C0, 8'h00, 4);
      cmd(8'h0C, 16'h04C0, 8'h03, 4);
      apb(1, 8'h00, 16'h0000, 16'h0000);
      apb(0, 8'h00, 16'h0680, 16'hFFFF);
      cmd(8'h0C, 16'h0040, 8'h00, 4);
      drv_in.reserved_ref <= 16'($random(seed));
      cmd(8'h00, 16'h0684, 8'h00, 4);
      chk(drv_out.speed_ref, drv_in.reserved_ref, "rsv");
      cmd(8'h00, 16'h06C0, 8'h00, 4);
      chk({drv_out.stop_ramp, drv_out.speed_ref}, 17'h10000, "stop");
      for (int k = 0; k < 4; k++) chk(npul[k], epul[k], "pulses");
      print_verdict();
   end
endmodule : servo_drive_flag_words_tb
